// ---- logic/csor_pkg.sv ----
// constants for the core status, option and trim register bank
package csor_pkg;
    // register file addresses
    localparam logic [4:0] CSOR_ADDR_STATUS  = 5'h03;
    localparam logic [4:0] CSOR_ADDR_TRIM    = 5'h05;
    // status bit positions
    localparam int         CSOR_ST_WAKE      = 7;
    localparam int         CSOR_ST_SPARE     = 6;
    localparam int         CSOR_ST_PAGE      = 5;
    localparam int         CSOR_ST_TIMEOUT   = 4;
    localparam int         CSOR_ST_POWERDOWN = 3;
    localparam int         CSOR_ST_ZERO      = 2;
    localparam int         CSOR_ST_DCARRY    = 1;
    localparam int         CSOR_ST_CARRY     = 0;
    // option bit positions
    localparam int         CSOR_OPT_WAKE_N   = 7;
    localparam int         CSOR_OPT_PULL_N   = 6;
    localparam int         CSOR_OPT_TCS      = 5;
    localparam int         CSOR_OPT_TSE      = 4;
    localparam int         CSOR_OPT_PSA      = 3;
    localparam int         CSOR_OPT_PS_HI    = 2;
    // trim field sits in bits 7:2 of its register
    localparam int         CSOR_TRIM_LSB     = 2;
    localparam int         CSOR_TIMER_PIN    = 2;
    localparam int         CSOR_INPUT_ONLY   = 3;
    // reset values
    localparam logic [7:0] CSOR_OPT_RST      = 8'hFF;
    localparam logic [5:0] CSOR_TRIM_RST     = 6'h20;
    localparam logic [5:0] CSOR_DIR_RST      = 6'h3F;
    // pins with pull-up and wake-on-change: 0, 1 and 3
    localparam logic [5:0] CSOR_WEAK_MASK    = 6'h0B;
    localparam logic [3:0] CSOR_DIV_ONE      = 4'h1;
    // instruction classes presented by the core
    localparam logic [2:0] CSOR_OP_MOVE      = 3'h0;
    localparam logic [2:0] CSOR_OP_ADD       = 3'h1;
    localparam logic [2:0] CSOR_OP_SUB       = 3'h2;
    localparam logic [2:0] CSOR_OP_LOGIC     = 3'h3;
    localparam logic [2:0] CSOR_OP_RRF       = 3'h4;
    localparam logic [2:0] CSOR_OP_RLF       = 3'h5;
    localparam logic [2:0] CSOR_OP_CLR       = 3'h6;

    typedef struct packed {
        logic       z_we;
        logic       dc_we;
        logic       c_we;
        logic       z;
        logic       dc;
        logic       c;
        logic [7:0] res;
    } csor_alu_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] option;
        logic [5:0] trim;
        logic [5:0] dir;
        logic [7:0] result;
    } csor_state_t;
endpackage

// ---- logic/csor_regs.sv ----
// core status, option, direction and trim registers with flag logic
//
// Contract
// R1 - status as target: flags come from result only
// R2 - clear of status: upper clear, zero set
// R3 - software alters status by bit or move
// R4 - carry on add, not-borrow on subtract
// R5 - rotates load carry from lsb or msb
// R6 - option write-only, loaded from working register
// R7 - every reset sets option to all ones
// R8 - output direction disables pull-up and wake
// R9 - external timer clock forces pin 2 input
// R10 - option bit 7 low enables pin wake
// R11 - option bit 6 low enables pull-ups
// R12 - option bit 5 selects timer clock source
// R13 - option bit 4 selects timer pin edge
// R14 - option bit 3 assigns prescaler
// R15 - prescaler divides 2^(n+1) timer, 2^n watchdog
// R16 - six-bit trim, larger means faster oscillator
// R17 - wake reset flag set only by wake reset; a status write also loads it from the result
// R18 - page bit feeds pc bit 9, reset clears
// R19 - timeout, powerdown read-only, event driven
// R20 - zero flag and digit carry from result
`timescale 1ns/1ps
`default_nettype none
module csor_regs
    import csor_pkg::*;
(
    // clock, reset, enable
    input  wire logic       SYS_CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    // cause of the reset, read while SRST is high
    input  wire logic       RESET_IS_POR,
    input  wire logic       RESET_IS_WAKE,
    // instruction execution from the core
    input  wire logic       EXEC,
    input  wire logic [2:0] ALU_OP,
    input  wire logic [7:0] OPERAND_F,
    input  wire logic [7:0] OPERAND_W,
    input  wire logic       FILE_WE,
    input  wire logic [4:0] FILE_ADDR,
    input  wire logic       OPTION_LOAD,
    input  wire logic       DIR_LOAD,
    // watchdog and sleep events
    input  wire logic       WDT_CLEAR,
    input  wire logic       SLEEP_EXEC,
    input  wire logic       WDT_TIMEOUT,
    // readback and result
    output logic      [7:0] RESULT_OUT,
    output logic      [7:0] STATUS_OUT,
    output logic      [7:0] TRIM_OUT,
    // settings for pins, timer, watchdog and oscillator
    output logic      [5:0] PIN_DRIVE,
    output logic      [5:0] PULLUP_EN,
    output logic      [5:0] WAKE_EN,
    output logic            TIMER_CLK_EXT,
    output logic            TIMER_FALL_EDGE,
    output logic            PRESCALE_TO_WDT,
    output logic      [3:0] TIMER_DIV_LOG2,
    output logic      [3:0] WDT_DIV_LOG2,
    output logic            PAGE_SEL,
    output logic      [5:0] OSC_TRIM
);

    csor_state_t st_r;
    csor_state_t st_nxt;
    csor_alu_t   alu;

    // arithmetic and flag results of one instruction
    function automatic csor_alu_t alu_eval(input logic [2:0] op, input logic [7:0] f,
                                           input logic [7:0] w, input logic cin);
        csor_alu_t  a;
        logic [8:0] s9;
        logic [4:0] s5;
        a  = '0;
        s9 = '0;
        s5 = '0;
        a.res = f;
        case (op)
            CSOR_OP_ADD:
            begin
                s9 = {1'b0, f} + {1'b0, w};
                s5 = {1'b0, f[3:0]} + {1'b0, w[3:0]};
                a.res = s9[7:0];
                a.c = s9[8];                                                  // R4
                a.dc = s5[4];                                                 // R20
                a.z_we = 1'b1;
                a.dc_we = 1'b1;
                a.c_we = 1'b1;
            end
            CSOR_OP_SUB:
            begin
                // two's complement add: carry out is the no-borrow sense
                s9 = {1'b0, f} + {1'b0, ~w} + 9'h001;
                s5 = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                a.res = s9[7:0];
                a.c = s9[8];                                                  // R4
                a.dc = s5[4];                                                 // R20
                a.z_we = 1'b1;
                a.dc_we = 1'b1;
                a.c_we = 1'b1;
            end
            CSOR_OP_LOGIC:
            begin
                a.z_we = 1'b1;
            end
            CSOR_OP_RRF:
            begin
                a.res = {cin, f[7:1]};
                a.c = f[0];                                                   // R5
                a.c_we = 1'b1;
            end
            CSOR_OP_RLF:
            begin
                a.res = {f[6:0], cin};
                a.c = f[7];                                                   // R5
                a.c_we = 1'b1;
            end
            CSOR_OP_CLR:
            begin
                a.res = 8'h00;
                a.z_we = 1'b1;
            end
            default:
            begin
                a.res = f;
            end
        endcase
        a.z = (a.res == 8'h00);                                               // R20
        return a;
    endfunction

    always_comb
    begin
        logic [7:0] s;
        logic       flag_op;
        alu = alu_eval(ALU_OP, OPERAND_F, OPERAND_W, st_r.status[CSOR_ST_CARRY]);
        st_nxt = st_r;
        s = st_r.status;
        flag_op = alu.z_we | alu.dc_we | alu.c_we;
        if (SRST)
        begin
            s[CSOR_ST_WAKE] = RESET_IS_WAKE;                                  // R17
            s[CSOR_ST_SPARE] = 1'b0;
            s[CSOR_ST_PAGE] = 1'b0;                                           // R18
            if (RESET_IS_POR)
            begin
                s = '0;
                s[CSOR_ST_TIMEOUT] = 1'b1;                                    // R19
                s[CSOR_ST_POWERDOWN] = 1'b1;
            end
            st_nxt.status = s;
            st_nxt.option = CSOR_OPT_RST;                                     // R7
            st_nxt.dir = CSOR_DIR_RST;
            if (RESET_IS_POR)
            begin
                st_nxt.trim = CSOR_TRIM_RST;
                st_nxt.result = '0;
            end
        end
        else if (CE)
        begin
            if (EXEC)
            begin
                st_nxt.result = alu.res;
                if (alu.z_we)
                    s[CSOR_ST_ZERO] = alu.z;                                  // R20
                if (alu.dc_we)
                    s[CSOR_ST_DCARRY] = alu.dc;
                if (alu.c_we)
                    s[CSOR_ST_CARRY] = alu.c;
                if (FILE_WE && FILE_ADDR == CSOR_ADDR_STATUS)
                begin
                    // upper three bits always take the result
                    s[CSOR_ST_WAKE] = alu.res[CSOR_ST_WAKE];                  // R2
                    s[CSOR_ST_SPARE] = alu.res[CSOR_ST_SPARE];
                    s[CSOR_ST_PAGE] = alu.res[CSOR_ST_PAGE];
                    // flag-updating instructions lose their write to the flags
                    if (!flag_op)
                    begin
                        s[CSOR_ST_ZERO] = alu.res[CSOR_ST_ZERO];              // R1
                        s[CSOR_ST_DCARRY] = alu.res[CSOR_ST_DCARRY];
                        s[CSOR_ST_CARRY] = alu.res[CSOR_ST_CARRY];
                    end
                end
                if (FILE_WE && FILE_ADDR == CSOR_ADDR_TRIM)
                    st_nxt.trim = alu.res[7:CSOR_TRIM_LSB];                   // R16
            end
            // timeout and powerdown are never written by the file write of an instruction
            if (WDT_CLEAR)
            begin
                s[CSOR_ST_TIMEOUT] = 1'b1;                                    // R19
                s[CSOR_ST_POWERDOWN] = 1'b1;
            end
            if (SLEEP_EXEC)
            begin
                s[CSOR_ST_TIMEOUT] = 1'b1;
                s[CSOR_ST_POWERDOWN] = 1'b0;                                  // R19
            end
            if (WDT_TIMEOUT)
                s[CSOR_ST_TIMEOUT] = 1'b0;                                    // R19
            st_nxt.status = s;
            if (OPTION_LOAD)
                st_nxt.option = OPERAND_W;                                    // R6
            if (DIR_LOAD)
                st_nxt.dir = OPERAND_W[5:0];
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        st_r <= st_nxt;
    end

    // option has no read path at all
    assign RESULT_OUT = st_r.result;
    assign STATUS_OUT = st_r.status;
    assign TRIM_OUT = {st_r.trim, {CSOR_TRIM_LSB{1'b0}}};
    assign OSC_TRIM = st_r.trim;                                              // R16
    assign PAGE_SEL = st_r.status[CSOR_ST_PAGE];                              // R18

    assign TIMER_CLK_EXT = st_r.option[CSOR_OPT_TCS];                         // R12
    assign TIMER_FALL_EDGE = st_r.option[CSOR_OPT_TSE];                       // R13
    assign PRESCALE_TO_WDT = st_r.option[CSOR_OPT_PSA];                       // R14
    // divide ratio as a power of two, so the consumer shifts and never multiplies
    assign TIMER_DIV_LOG2 = PRESCALE_TO_WDT ? 4'h0 :
                            {1'b0, st_r.option[CSOR_OPT_PS_HI:0]} + CSOR_DIV_ONE; // R15
    assign WDT_DIV_LOG2 = PRESCALE_TO_WDT ? {1'b0, st_r.option[CSOR_OPT_PS_HI:0]} :
                          4'h0;                                               // R15

    // a pin driven as output never gets pull-up or wake
    assign PULLUP_EN = {6{~st_r.option[CSOR_OPT_PULL_N]}} & st_r.dir & CSOR_WEAK_MASK; // R8 R11
    assign WAKE_EN = {6{~st_r.option[CSOR_OPT_WAKE_N]}} & st_r.dir & CSOR_WEAK_MASK;   // R8 R10

    always_comb
    begin
        PIN_DRIVE = ~st_r.dir;
        PIN_DRIVE[CSOR_INPUT_ONLY] = 1'b0;
        if (TIMER_CLK_EXT)
            PIN_DRIVE[CSOR_TIMER_PIN] = 1'b0;                                 // R9
    end

    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    logic [8:0] chk_add_sum;
    logic       chk_sub_nb;
    assign chk_add_sum = {1'b0, OPERAND_F} + {1'b0, OPERAND_W};
    assign chk_sub_nb = (OPERAND_F >= OPERAND_W);

    sequence s_status_op(logic [2:0] op);
        CE && !SRST && EXEC && FILE_WE && FILE_ADDR == CSOR_ADDR_STATUS && ALU_OP == op
        && !WDT_CLEAR && !SLEEP_EXEC && !WDT_TIMEOUT;
    endsequence

    sequence s_opt_load;
        CE && OPTION_LOAD && !SRST;
    endsequence

    chk_add_carry_flag: assert property (s_status_op(CSOR_OP_ADD) |=>           // R1
        STATUS_OUT[CSOR_ST_CARRY] == $past(chk_add_sum[8])
        && STATUS_OUT[CSOR_ST_ZERO] == ($past(chk_add_sum[7:0]) == 8'h00))
        else $error("status flags not taken from add result");

    chk_clr_status_bits: assert property (s_status_op(CSOR_OP_CLR) |=>          // R2
        STATUS_OUT[7:5] == 3'h0 && STATUS_OUT[CSOR_ST_ZERO]
        && STATUS_OUT[4:3] == $past(STATUS_OUT[4:3])
        && STATUS_OUT[1:0] == $past(STATUS_OUT[1:0]))
        else $error("clear of status gave wrong bits");

    chk_sub_borrow_flag: assert property (CE && EXEC && ALU_OP == CSOR_OP_SUB |=> // R4
        STATUS_OUT[CSOR_ST_CARRY] == $past(chk_sub_nb))
        else $error("subtract carry is not the no-borrow sense");

    chk_rotate_carry_in: assert property (CE && EXEC && ALU_OP == CSOR_OP_RRF   // R5
        ##1 CE && EXEC && ALU_OP == CSOR_OP_RLF |=>
        STATUS_OUT[CSOR_ST_CARRY] == $past(OPERAND_F[7])
        && $past(STATUS_OUT[CSOR_ST_CARRY]) == $past(OPERAND_F[0], 2))
        else $error("rotate did not load carry from operand edge bit");

    chk_option_load_value: assert property (s_opt_load ##1 (!OPTION_LOAD)[*2] |-> // R6
        {~WAKE_EN[0] | ~st_r.dir[0], TIMER_CLK_EXT, TIMER_FALL_EDGE}
        == {$past(OPERAND_W[CSOR_OPT_WAKE_N], 2) | ~st_r.dir[0],
            $past(OPERAND_W[CSOR_OPT_TCS], 2), $past(OPERAND_W[CSOR_OPT_TSE], 2)})
        else $error("option settings do not follow the loaded value");

    chk_option_reset_ones: assert property (@(posedge SYS_CLK) disable iff (1'b0) // R7
        SRST |=> TIMER_CLK_EXT && TIMER_FALL_EDGE && PRESCALE_TO_WDT
        && PULLUP_EN == 6'h00 && WAKE_EN == 6'h00 && WDT_DIV_LOG2 == 4'h7)
        else $error("reset did not set option to all ones");

    chk_dir_gates_pullup: assert property ((PULLUP_EN & PIN_DRIVE) == 6'h00 // R8
        && (WAKE_EN & PIN_DRIVE) == 6'h00)
        else $error("driven pin has pull-up or wake enabled");

    chk_timer_pin_input: assert property (TIMER_CLK_EXT |-> !PIN_DRIVE[CSOR_TIMER_PIN]) // R9
        else $error("timer pin driven while external clock selected");

    chk_prescale_ratio: assert property (s_opt_load |=>                         // R15
        (TIMER_DIV_LOG2 == ($past(OPERAND_W[CSOR_OPT_PSA]) ? 4'h0 :
            {1'b0, $past(OPERAND_W[2:0])} + 4'h1))
        && (WDT_DIV_LOG2 == ($past(OPERAND_W[CSOR_OPT_PSA]) ?
            {1'b0, $past(OPERAND_W[2:0])} : 4'h0)))
        else $error("prescaler ratio wrong for assignment");

    chk_wake_reset_flag: assert property (@(posedge SYS_CLK) disable iff (1'b0) // R17
        SRST |=> STATUS_OUT[CSOR_ST_WAKE] == ($past(RESET_IS_WAKE) && !$past(RESET_IS_POR))
        && !PAGE_SEL)
        else $error("reset flags or page bit wrong after reset");

    chk_sleep_powerdown: assert property (CE && SLEEP_EXEC && !WDT_TIMEOUT && !WDT_CLEAR // R19
        |=> !STATUS_OUT[CSOR_ST_POWERDOWN] && STATUS_OUT[CSOR_ST_TIMEOUT])
        else $error("sleep did not clear powerdown flag");

endmodule
`default_nettype wire

// ---- bench/core_status_option_regs_tb.sv ----
// self-checking bench for the core status, option and trim register bank
`timescale 1ns/1ps
`default_nettype none
module core_status_option_regs_tb
    import csor_pkg::*;
;
    logic        sys_clk, srst, ce, por, wake, exec, file_we, opt_ld, dir_ld;
    logic        wdt_clr, sleep, wdt_to, tclk_ext, tfall, ps_wdt, page_sel;
    logic [2:0]  alu_op;
    logic [4:0]  file_addr;
    logic [7:0]  op_f, op_w, result_out, status_out, trim_out;
    logic [5:0]  pin_drive, pullup_en, wake_en, osc_trim, m_trim, m_dir;
    logic [3:0]  tdiv, wdiv;
    logic [7:0]  m_status, m_option, m_result;
    logic [31:0] lfsr;
    int          bad_count, tests_run;

    csor_regs dut (
        .SYS_CLK(sys_clk), .SRST(srst), .CE(ce), .RESET_IS_POR(por), .RESET_IS_WAKE(wake),
        .EXEC(exec), .ALU_OP(alu_op), .OPERAND_F(op_f), .OPERAND_W(op_w), .FILE_WE(file_we),
        .FILE_ADDR(file_addr), .OPTION_LOAD(opt_ld), .DIR_LOAD(dir_ld), .WDT_CLEAR(wdt_clr),
        .SLEEP_EXEC(sleep), .WDT_TIMEOUT(wdt_to), .RESULT_OUT(result_out),
        .STATUS_OUT(status_out), .TRIM_OUT(trim_out), .PIN_DRIVE(pin_drive),
        .PULLUP_EN(pullup_en), .WAKE_EN(wake_en), .TIMER_CLK_EXT(tclk_ext),
        .TIMER_FALL_EDGE(tfall), .PRESCALE_TO_WDT(ps_wdt), .TIMER_DIV_LOG2(tdiv),
        .WDT_DIV_LOG2(wdiv), .PAGE_SEL(page_sel), .OSC_TRIM(osc_trim)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        logic [31:0] x;
        begin
            x = s;
            for (int i = 0; i < 32; i++)
                x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
            return x;
        end
    endfunction

    task automatic print_verdict();
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                bad_count++;
                $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // model state describes the design after the next rising edge
    task automatic model_edge();
        int         f, w, wn, r, c, dc, z;
        logic       st;
        logic [2:0] op;
        begin
            if (srst)
            begin
                m_option = CSOR_OPT_RST;
                m_dir = CSOR_DIR_RST;
                m_status = {wake, 2'h0, m_status[4:0]};
                if (por)
                begin
                    m_status = 8'h18;
                    m_trim = CSOR_TRIM_RST;
                    m_result = 8'h00;
                end
                return;
            end
            if (!ce)
                return;
            op = alu_op;
            f = op_f;
            w = op_w;
            c = m_status[0];
            dc = m_status[1];
            z = m_status[2];
            wn = (op == CSOR_OP_SUB) ? 16 - w % 16 : w % 16;
            r = (op == CSOR_OP_ADD) ? f + w : (op == CSOR_OP_SUB) ? f - w + 256 : f;
            // move and logic classes pass the file operand through
            if (op == CSOR_OP_RRF) r = c * 128 + f / 2;
            if (op == CSOR_OP_RLF) r = f * 2 + c;
            if (op == CSOR_OP_CLR) r = 0;
            if (op == CSOR_OP_ADD || op == CSOR_OP_SUB)
            begin
                c = r / 256;
                dc = (f % 16 + wn) / 16;
            end
            if (op == CSOR_OP_RRF) c = f % 2;
            if (op == CSOR_OP_RLF) c = f / 128;
            if (op inside {CSOR_OP_ADD, CSOR_OP_SUB, CSOR_OP_LOGIC, CSOR_OP_CLR}) z = (r % 256 == 0);
            st = file_we && file_addr == CSOR_ADDR_STATUS;
            if (exec)
            begin
                m_result = r[7:0];
                m_status[2:0] = (st && op == CSOR_OP_MOVE) ? r[2:0] : {z[0], dc[0], c[0]};
                if (st) m_status[7:5] = r[7:5];
                if (file_we && file_addr == CSOR_ADDR_TRIM) m_trim = r[7:2];
            end
            if (wdt_clr || sleep) m_status[4] = 1'b1;
            if (wdt_to) m_status[4] = 1'b0;
            if (wdt_clr) m_status[3] = 1'b1;
            if (sleep) m_status[3] = 1'b0;
            if (opt_ld) m_option = op_w;
            if (dir_ld) m_dir = op_w[5:0];
        end
    endtask

    task automatic compare_all();
        logic [5:0] in_pins;
        begin
            in_pins = m_dir & CSOR_WEAK_MASK;
            check(result_out, m_result);
            check(status_out, m_status);
            check(trim_out, {m_trim, 2'h0});
            check({2'h0, pin_drive}, {2'h0, ~m_dir & 6'h37 & ~{3'h0, m_option[5], 2'h0}});
            check({2'h0, pullup_en}, {2'h0, in_pins & {6{~m_option[6]}}});
            check({2'h0, wake_en}, {2'h0, in_pins & {6{~m_option[7]}}});
            check({7'h00, tclk_ext}, {7'h00, m_option[5]});
            check({7'h00, tfall}, {7'h00, m_option[4]});
            check({7'h00, ps_wdt}, {7'h00, m_option[3]});
            check({4'h0, tdiv}, m_option[3] ? 8'h00 : {5'h00, m_option[2:0]} + 8'h01);
            check({4'h0, wdiv}, m_option[3] ? {5'h00, m_option[2:0]} : 8'h00);
            check({7'h00, page_sel}, {7'h00, m_status[5]});
            check({2'h0, osc_trim}, {2'h0, m_trim});
        end
    endtask

    // inputs change at the falling edge, outputs are compared one cycle later
    task automatic tick();
        begin
            model_edge();
            @(negedge sys_clk);
            compare_all();
        end
    endtask

    task automatic do_op(input logic [2:0] op, input logic [7:0] f, input logic [7:0] w,
                         input logic [4:0] addr);
        begin
            {srst, opt_ld, dir_ld, wdt_clr, sleep, wdt_to} = 6'h00;
            {ce, exec, file_we} = 3'h7;
            alu_op = op;
            op_f = f;
            op_w = w;
            file_addr = addr;
            tick();
        end
    endtask

    task automatic drive_random();
        begin
            lfsr = lfsr_next(lfsr);
            srst = lfsr[7:0] == 8'h5A;
            {por, wake} = lfsr[9:8];
            ce = lfsr[12:10] != 3'h0;
            exec = lfsr[13] | lfsr[14];
            alu_op = (lfsr[17:15] == 3'h7) ? CSOR_OP_CLR : lfsr[17:15];
            file_we = lfsr[18];
            file_addr = lfsr[19] ? CSOR_ADDR_STATUS : (lfsr[20] ? CSOR_ADDR_TRIM : lfsr[25:21]);
            {opt_ld, dir_ld} = {lfsr[26] & lfsr[27], lfsr[28] & lfsr[29]};
            lfsr = lfsr_next(lfsr);
            op_w = lfsr[7:0];
            // a move result is then the same whichever operand the core forwards
            op_f = (alu_op == CSOR_OP_MOVE) ? op_w : lfsr[15:8];
            wdt_clr = lfsr[18:16] == 3'h0;
            sleep = lfsr[21:19] == 3'h0;
            wdt_to = lfsr[24:22] == 3'h0;
        end
    endtask

    initial
    begin
        #40000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        {srst, por, wake, ce} = 4'hF;
        {exec, file_we, opt_ld, dir_ld, wdt_clr, sleep, wdt_to} = 7'h00;
        alu_op = CSOR_OP_MOVE;
        file_addr = 5'h00;
        op_f = 8'h00;
        op_w = 8'h00;
        bad_count = 0;
        tests_run = 0;
        lfsr = 32'h2730D931;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        tick();
        do_op(CSOR_OP_ADD, 8'h0F, 8'h01, CSOR_ADDR_STATUS);
        check(status_out, 8'h1A);
        do_op(CSOR_OP_MOVE, 8'hE0, 8'hE0, CSOR_ADDR_STATUS);
        check(status_out, 8'hF8);
        do_op(CSOR_OP_CLR, 8'hFF, 8'h00, CSOR_ADDR_STATUS);
        check(status_out, 8'h1C);
        do_op(CSOR_OP_SUB, 8'h01, 8'h02, 5'h10);
        check(status_out, 8'h18);
        do_op(CSOR_OP_RLF, 8'h80, 8'h00, 5'h10);
        check(status_out, 8'h19);
        for (int i = 0; i < 16; i++)
        begin
            do_op(CSOR_OP_MOVE, 8'h00, 8'h00, 5'h10);
            {opt_ld, dir_ld} = 2'h3;
            op_w = i[7:0] * 8'h1D;
            tick();
        end
        repeat (3000)
        begin
            drive_random();
            tick();
        end
        print_verdict();
    end
endmodule
`default_nettype wire
